// file: ocp_channel.sv
// Output compare channel with pulse and PWM modes, AHB-Lite registers.
// Assumes time bases count in the hclk domain and inputs are synchronous.
//
// Overview of operation
// (RULE_01) Idle-stop bit set halts the channel while the processor idles.
// (RULE_02) Fault flag set and cleared by hardware only, used in mode 111.
// (RULE_03) Time base select bit picks time_base_b when 1, time_base_a when 0.
// (RULE_04) Mode 111 is PWM with fault input enabled and recorded in flag.
// (RULE_05) Mode 110 is PWM with the fault input ignored.
// (RULE_06) Mode 101 starts low, then produces continuous pulses.
// (RULE_07) Mode 100 starts low, produces one pulse, then stays low.
// (RULE_08) Mode 011 toggles the pin on every compare event.
// (RULE_09) Mode 010 starts high, compare event forces pin low.
// (RULE_10) Mode 001 starts low, compare event forces pin high.
// (RULE_11) Mode 000 disables the channel entirely.
// (RULE_12) First fault input serves channels one to four, second serves five.
// (RULE_13) Unimplemented control bits read zero and ignore writes.
// (RULE_14) Software routes the channel output to a remappable pin; here channel_output_pin is a fixed port with no routing control.
// (RULE_15) Compare event when selected time base equals the compare value.
// (RULE_16) After reset all writable control bits are zero.
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
module ocp_channel
   import ocp_pkg::*;
#(
   parameter int CHANNEL_INDEX = 1
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        clk_en,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic [15:0] time_base_a,
   input  wire logic [15:0] time_base_b,
   input  wire logic        cpu_idle,
   input  wire logic        fault_input_first,
   input  wire logic        fault_input_second,
   output logic             channel_output_pin,
   output logic             irq
);
   logic             dph_wr_q, dph_wr_d, dph_rd_q, dph_rd_d;
   logic [7:0]       dph_addr_q, dph_addr_d;
   logic             idle_stop_select_q, idle_stop_select_d;
   logic             time_base_select_q, time_base_select_d;
   logic [2:0]       channel_mode_field_q, channel_mode_field_d;
   logic             fault_status_flag_q, fault_status_flag_d;
   logic [15:0]      cmp_main_q, cmp_main_d, cmp_sec_q, cmp_sec_d;
   logic [15:0]      tb_prev_q, tb_prev_d, tb_sel;
   logic [2:0]       mask_q, mask_d;
   logic [2:0]       stat_q, stat_d, stat_set, stat_clr;
   logic [31:0]      hrdata_d;
   logic             irq_d, pin_q, pin_d;
   ocp_state_e       st_q, st_d;
   logic             addr_ok, wr_ctrl, wr_any, mode_chg, halted, run;
   logic             evt_main, evt_sec, per_start, fault_in;

   // Address phase capture, zero wait state
   assign addr_ok = hsel && htrans[1] && hready;
   always_comb
   begin
      dph_wr_d   = addr_ok && hwrite;
      dph_rd_d   = addr_ok && !hwrite;
      dph_addr_d = addr_ok ? haddr[7:0] : dph_addr_q;
   end

   // Data phase write decode
   assign wr_any   = dph_wr_q;
   assign wr_ctrl  = wr_any && (dph_addr_q == OCP_ADDR_CTRL);
   assign mode_chg = wr_ctrl && (hwdata[OCP_MODE_LSB +: OCP_MODE_W] != channel_mode_field_q);

   // Time base selection and compare events
   assign tb_sel    = time_base_select_q ? time_base_b : time_base_a; // [RULE_03]
   assign halted    = idle_stop_select_q && cpu_idle; // [RULE_01]
   assign run       = (channel_mode_field_q != OCP_MODE_OFF) && !halted; // [RULE_11]
   assign evt_main  = run && (tb_sel == cmp_main_q) && (tb_sel != tb_prev_q); // [RULE_15]
   assign evt_sec   = run && (tb_sel == cmp_sec_q) && (tb_sel != tb_prev_q);
   assign per_start = run && (tb_sel == OCP_TB_ZERO) && (tb_prev_q != OCP_TB_ZERO);
   assign fault_in  = (CHANNEL_INDEX > OCP_LAST_FAULT_A_CH) ? fault_input_second
                                                            : fault_input_first; // [RULE_12]

   // Software-writable registers; reserved bits never stored
   always_comb
   begin
      idle_stop_select_d   = idle_stop_select_q;
      time_base_select_d   = time_base_select_q;
      channel_mode_field_d = channel_mode_field_q;
      cmp_main_d           = cmp_main_q;
      cmp_sec_d            = cmp_sec_q;
      mask_d               = mask_q;
      if (wr_ctrl)
      begin
         idle_stop_select_d   = hwdata[OCP_BIT_SIDL]; // [RULE_13]
         time_base_select_d   = hwdata[OCP_BIT_TSEL];
         channel_mode_field_d = hwdata[OCP_MODE_LSB +: OCP_MODE_W];
      end
      if (wr_any && dph_addr_q == OCP_ADDR_CMPR)
         cmp_main_d = hwdata[15:0];
      if (wr_any && dph_addr_q == OCP_ADDR_CMPS)
         cmp_sec_d = hwdata[15:0];
      if (wr_any && dph_addr_q == OCP_ADDR_MASK)
         mask_d = hwdata[OCP_IRQ_W-1:0];
   end

   // Fault flag: hardware sets on fault in mode 111, clears at a clean period start
   always_comb
   begin
      fault_status_flag_d = fault_status_flag_q;
      if (run && channel_mode_field_q == OCP_MODE_PWMF && !fault_in && per_start)
         fault_status_flag_d = 1'b0; // [RULE_02]
      if (run && channel_mode_field_q == OCP_MODE_PWMF && fault_in)
         fault_status_flag_d = 1'b1; // [RULE_04]
   end

   // Output pin and pulse sequencer
   always_comb
   begin
      pin_d = pin_q;
      st_d  = st_q;
      if (mode_chg)
      begin
         pin_d = (hwdata[OCP_MODE_LSB +: OCP_MODE_W] == OCP_MODE_SETLO); // [RULE_09] [RULE_10]
         st_d  = OCP_ST_ARM; // [RULE_06] [RULE_07]
      end
      else if (channel_mode_field_q == OCP_MODE_OFF)
      begin
         pin_d = 1'b0; // [RULE_11]
         st_d  = OCP_ST_OFF;
      end
      else if (run)
      begin
         unique case (channel_mode_field_q)
            OCP_MODE_SETHI:  if (evt_main) pin_d = 1'b1; // [RULE_10]
            OCP_MODE_SETLO:  if (evt_main) pin_d = 1'b0; // [RULE_09]
            OCP_MODE_TOGGLE: if (evt_main) pin_d = !pin_q; // [RULE_08]
            OCP_MODE_SINGLE, OCP_MODE_CONT:
            begin
               unique case (st_q)
                  OCP_ST_ARM:
                     if (evt_main)
                     begin
                        pin_d = 1'b1;
                        st_d  = OCP_ST_HIGH;
                     end
                  OCP_ST_HIGH:
                     if (evt_sec)
                     begin
                        pin_d = 1'b0;
                        st_d  = (channel_mode_field_q == OCP_MODE_CONT) ? OCP_ST_ARM : OCP_ST_DONE; // [RULE_06] [RULE_07]
                     end
                  OCP_ST_DONE: pin_d = 1'b0; // [RULE_07]
                  default:     st_d  = OCP_ST_ARM;
               endcase
            end
            OCP_MODE_PWM, OCP_MODE_PWMF:
            begin
               if (channel_mode_field_q == OCP_MODE_PWMF && fault_in)
                  pin_d = 1'b0; // [RULE_04]
               else if (evt_main)
                  pin_d = 1'b0; // [RULE_05]
               else if (per_start && cmp_main_q != OCP_CMP_RST)
                  pin_d = 1'b1;
            end
            default: pin_d = 1'b0;
         endcase
      end
   end

   // Interrupt sources and read mux using post-write values
   always_comb
   begin
      stat_set = '0;
      stat_set[OCP_IRQ_CMP]  = evt_main;
      stat_set[OCP_IRQ_FLT]  = fault_status_flag_d && !fault_status_flag_q;
      stat_set[OCP_IRQ_DONE] = (st_d == OCP_ST_DONE) && (st_q != OCP_ST_DONE);
      stat_clr = (wr_any && dph_addr_q == OCP_ADDR_STAT) ? hwdata[OCP_IRQ_W-1:0] : '0;
      hrdata_d = OCP_WORD_ZERO;
      if (addr_ok && !hwrite)
      begin
         unique case (haddr[7:0])
            OCP_ADDR_CTRL:
            begin
               hrdata_d[OCP_BIT_SIDL]                     = idle_stop_select_d; // [RULE_13]
               hrdata_d[OCP_BIT_FLT]                      = fault_status_flag_d;
               hrdata_d[OCP_BIT_TSEL]                     = time_base_select_d;
               hrdata_d[OCP_MODE_LSB +: OCP_MODE_W]       = channel_mode_field_d;
            end
            OCP_ADDR_CMPR: hrdata_d[15:0] = cmp_main_d;
            OCP_ADDR_CMPS: hrdata_d[15:0] = cmp_sec_d;
            OCP_ADDR_STAT: hrdata_d[OCP_IRQ_W-1:0] = stat_d;
            OCP_ADDR_MASK: hrdata_d[OCP_IRQ_W-1:0] = mask_d;
            default:       hrdata_d = OCP_WORD_ZERO;
         endcase
      end
      irq_d = |(stat_d & mask_d);
   end

   // Time base history
   assign tb_prev_d = halted ? tb_prev_q : tb_sel;

   ocp_sticky #(
      .W       (OCP_IRQ_W)
   ) u_stat (
      .hclk    (hclk),
      .hresetn (hresetn),
      .clk_en  (clk_en),
      .set_in  (stat_set),
      .clr_in  (stat_clr),
      .flag_q  (stat_q),
      .flag_d  (stat_d)
   );

   // State registers; clock enable freezes everything
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dph_wr_q             <= 1'b0;
         dph_rd_q             <= 1'b0;
         dph_addr_q           <= OCP_ADDR_CTRL;
         idle_stop_select_q   <= 1'b0; // [RULE_16]
         time_base_select_q   <= 1'b0;
         channel_mode_field_q <= OCP_MODE_OFF;
         fault_status_flag_q  <= 1'b0;
         cmp_main_q           <= OCP_CMP_RST;
         cmp_sec_q            <= OCP_CMP_RST;
         mask_q               <= '0;
         tb_prev_q            <= OCP_TB_ZERO;
         pin_q                <= 1'b0;
         st_q                 <= OCP_ST_OFF;
         hrdata               <= OCP_WORD_ZERO;
         irq                  <= 1'b0;
         hreadyout            <= 1'b1;
         hresp                <= 1'b0;
      end
      else if (clk_en)
      begin
         dph_wr_q             <= dph_wr_d;
         dph_rd_q             <= dph_rd_d;
         dph_addr_q           <= dph_addr_d;
         idle_stop_select_q   <= idle_stop_select_d;
         time_base_select_q   <= time_base_select_d;
         channel_mode_field_q <= channel_mode_field_d;
         fault_status_flag_q  <= fault_status_flag_d;
         cmp_main_q           <= cmp_main_d;
         cmp_sec_q            <= cmp_sec_d;
         mask_q               <= mask_d;
         tb_prev_q            <= tb_prev_d;
         pin_q                <= pin_d;
         st_q                 <= st_d;
         hrdata               <= hrdata_d;
         irq                  <= irq_d;
         hreadyout            <= 1'b1;
         hresp                <= 1'b0;
      end
   end

   assign channel_output_pin = pin_q;

   // Checks on mode behaviour
   a_idle_halt_pin: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_01]
      (clk_en && halted && !wr_ctrl && channel_mode_field_q != OCP_MODE_OFF) |=> $stable(pin_q))
      else $error("pin moved while halted in idle");
   a_flag_mode_only: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_02]
      $rose(fault_status_flag_q) |-> $past(channel_mode_field_q) == OCP_MODE_PWMF)
      else $error("fault flag set outside fault mode");
   // Selected base arriving at the compare value must raise the event flag
   a_tb_select_evt: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_03] [RULE_15]
      (clk_en && $past(clk_en) && run && $past(run) && time_base_select_q == $past(time_base_select_q)
       && (time_base_select_q ? time_base_b : time_base_a) == cmp_main_q
       && (time_base_select_q ? $past(time_base_b) : $past(time_base_a)) != cmp_main_q)
      |=> stat_q[OCP_IRQ_CMP])
      else $error("compare event missed on selected time base");
   a_fault_forces_low: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_04]
      (clk_en && run && !wr_ctrl && channel_mode_field_q == OCP_MODE_PWMF && fault_in)
      |=> (!pin_q && fault_status_flag_q))
      else $error("fault not applied in mode 111");
   a_pwm_no_fault: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_05]
      (clk_en && !wr_ctrl && channel_mode_field_q == OCP_MODE_PWM && per_start && !evt_main
       && cmp_main_q != OCP_CMP_RST) |=> pin_q)
      else $error("pwm period start blocked");
   a_single_done_low: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_07]
      (clk_en && st_q == OCP_ST_DONE && channel_mode_field_q == OCP_MODE_SINGLE && !wr_ctrl)
      |=> (!pin_q && st_q == OCP_ST_DONE))
      else $error("single pulse repeated");
   a_toggle_evt: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_08]
      (clk_en && !wr_ctrl && channel_mode_field_q == OCP_MODE_TOGGLE && evt_main)
      |=> pin_q != $past(pin_q))
      else $error("toggle missed");
   a_setlo_init: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_09]
      (clk_en && mode_chg && hwdata[OCP_MODE_LSB +: OCP_MODE_W] == OCP_MODE_SETLO) |=> pin_q)
      else $error("mode 010 did not start high");
   a_off_low: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_11]
      (clk_en && channel_mode_field_q == OCP_MODE_OFF && !wr_ctrl) |=> (!pin_q && !$rose(stat_q[OCP_IRQ_CMP])))
      else $error("disabled channel active");
   a_ctrl_reserved: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_13]
      (clk_en && dph_rd_q && dph_addr_q == OCP_ADDR_CTRL) |-> (hrdata[15:14] == 2'h0 && hrdata[12:5] == 8'h00))
      else $error("reserved control bits not zero");
endmodule // ocp_channel

// file: ocp_pkg.sv
// Package for the output compare / PWM channel.
// Assumes a 32-bit AHB-Lite slave port and 16-bit time bases.
package ocp_pkg;
   // Register byte offsets
   localparam logic [7:0] OCP_ADDR_CTRL = 8'h00;
   localparam logic [7:0] OCP_ADDR_CMPR = 8'h04;
   localparam logic [7:0] OCP_ADDR_CMPS = 8'h08;
   localparam logic [7:0] OCP_ADDR_STAT = 8'h0C;
   localparam logic [7:0] OCP_ADDR_MASK = 8'h10;
   // Control field positions
   localparam int OCP_BIT_SIDL = 13;
   localparam int OCP_BIT_FLT  = 4;
   localparam int OCP_BIT_TSEL = 3;
   localparam int OCP_MODE_LSB = 0;
   localparam int OCP_MODE_W   = 3;
   // Mode codes
   localparam logic [2:0] OCP_MODE_OFF    = 3'h0;
   localparam logic [2:0] OCP_MODE_SETHI  = 3'h1;
   localparam logic [2:0] OCP_MODE_SETLO  = 3'h2;
   localparam logic [2:0] OCP_MODE_TOGGLE = 3'h3;
   localparam logic [2:0] OCP_MODE_SINGLE = 3'h4;
   localparam logic [2:0] OCP_MODE_CONT   = 3'h5;
   localparam logic [2:0] OCP_MODE_PWM    = 3'h6;
   localparam logic [2:0] OCP_MODE_PWMF   = 3'h7;
   // Interrupt status bits
   localparam int OCP_IRQ_W    = 3;
   localparam int OCP_IRQ_CMP  = 0;
   localparam int OCP_IRQ_FLT  = 1;
   localparam int OCP_IRQ_DONE = 2;
   // Reset values and widths
   localparam logic [15:0] OCP_CMP_RST   = 16'h0000;
   localparam logic [15:0] OCP_TB_ZERO   = 16'h0000;
   localparam logic [31:0] OCP_WORD_ZERO = 32'h0000_0000;
   localparam int          OCP_LAST_FAULT_A_CH = 4;
   // Pulse sequencer states, one-hot
   typedef enum logic [3:0] {
      OCP_ST_OFF  = 4'h1,
      OCP_ST_ARM  = 4'h2,
      OCP_ST_HIGH = 4'h4,
      OCP_ST_DONE = 4'h8
   } ocp_state_e;
endpackage

// file: ocp_sticky.sv
// Sticky status flags: hardware sets, software clears by writing one.
// Assumes set and clear arrive as single-cycle strobes in the hclk domain.
`timescale 1ns/1ns
module ocp_sticky #(
   parameter int W = 3
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] set_in,
   input  wire logic [W-1:0] clr_in,
   output logic      [W-1:0] flag_q,
   output logic      [W-1:0] flag_d
);
   // Set wins over a clear in the same cycle
   always_comb
   begin
      flag_d = (flag_q & ~clr_in) | set_in;
   end

   // Flag storage
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         flag_q <= '0;
      else if (clk_en)
         flag_q <= flag_d;
   end
endmodule // ocp_sticky

// file: ocp_load.sv
// Load model on the channel output pin, with an overcurrent trip.
// Assumes the hclk domain; the bench arms the trip.
`timescale 1ns/1ns
module ocp_load (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic pin_level,
   input  wire logic trip_arm,
   output logic      fault_level
);
   // Latch a fault once armed and driven high; the pin reaches the load
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         fault_level <= 1'b0;
      else
         fault_level <= trip_arm & (fault_level | pin_level); // Released only by disarming
   end
endmodule // ocp_load

// file: output_compare_pwm_channel_bench.sv
// Testbench for the output compare channel: bus master, time bases, load.
// Assumes one hclk domain at 100 MHz and a zero-wait-state slave.
`timescale 1ns/1ns
module output_compare_pwm_channel_bench import ocp_pkg::*;;
   logic        hclk = 1'b0;
   logic        hresetn, hsel, hwrite, hreadyout, hresp, pin, irq, pin5;
   logic        cpu_idle, flt_a, flt_b, trip, run_b, rd_ph, pin_q;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] tba, tbb, cmp;
   logic [31:0] expq[$];
   int          fail_count, checks, rises, edges, highs, r, e, h;

   ocp_channel dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .time_base_a(tba), .time_base_b(tbb),
      .cpu_idle(cpu_idle), .fault_input_first(flt_a), .fault_input_second(flt_b),
      .channel_output_pin(pin), .irq(irq));
   ocp_load load_u (.hclk(hclk), .hresetn(hresetn), .pin_level(pin), .trip_arm(trip), .fault_level(flt_a));
   // Fifth channel on the same bus, served by the second fault input
   ocp_channel #(.CHANNEL_INDEX(5)) dut5_u (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(), .hresp(), .hrdata(), .time_base_a(tba), .time_base_b(tbb), .cpu_idle(cpu_idle),
      .fault_input_first(flt_a), .fault_input_second(flt_b), .channel_output_pin(pin5), .irq());

   // Clock
   always #5 hclk = ~hclk;

   // Time bases (a wraps every 40 cycles) and pin statistics
   always @(posedge hclk)
   begin
      if (!hresetn)
      begin
         tba <= 16'h0000;
         tbb <= 16'h0005;
      end
      else
      begin
         tba <= (tba == 16'h0027) ? 16'h0000 : tba + 16'h0001;
         tbb <= run_b ? tbb + 16'h0001 : tbb;
      end
      pin_q <= pin;
      rises <= rises + int'(pin === 1'b1 && pin_q === 1'b0);
      edges <= edges + int'(pin !== pin_q);
      highs <= highs + int'(pin === 1'b1);
   end

   // Read results: oldest note against the data phase
   always @(posedge hclk)
      if (rd_ph && hreadyout === 1'b1)
      begin
         chk(hrdata, expq.pop_front());
         bchk(hresp, 1'b0);
      end

   task automatic chk(input logic [31:0] seen, input logic [31:0] x);
      checks++;
      if (seen !== x)
      begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, x);
      end
   endtask

   task automatic bchk(input logic s, input logic x);
      chk({31'h0, s}, {31'h0, x});
   endtask

   // Single word transfer; reads note their expected value
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= w ? d : hwdata;
      rd_ph <= !w;
      if (!w)
         expq.push_back(d);
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_ph <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      bus(1'b0, a, x);
   endtask

   // Pin rises, edges and high cycles over a window
   task automatic meas(input int n);
      int r0, e0, h0;
      r0 = rises;
      e0 = edges;
      h0 = highs;
      repeat (n) @(posedge hclk);
      r = rises - r0;
      e = edges - e0;
      h = highs - h0;
   endtask

   task automatic tend(input string s);
      $display("test %s done", s);
   endtask

   task automatic test_done;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Watchdog
   initial
   begin
      repeat (20000) @(posedge hclk);
      fail_count++;
      test_done;
   end

   // Main sequence
   initial
   begin
      {hsel, hwrite, htrans, haddr, hwdata, cpu_idle, flt_b, trip, run_b, rd_ph} = '0;
      {hresetn, hsize} = {1'b0, 3'h2};
      void'($urandom(84253));
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(OCP_ADDR_CTRL, 32'h0000_0000);
      wr(OCP_ADDR_CTRL, 32'hFFFF_FFFF);
      rd(OCP_ADDR_CTRL, 32'h0000_200F);
      rd(8'h14, 32'h0000_0000);
      wr(OCP_ADDR_CTRL, 32'h0000_0000);
      bchk(irq, 1'b0);
      tend("registers");
      wr(OCP_ADDR_CMPR, 32'h0000_000A);
      wr(OCP_ADDR_CTRL, 32'h0000_0009);
      repeat (60) @(posedge hclk);
      bchk(pin, 1'b0);
      run_b <= 1'b1;
      repeat (20) @(posedge hclk);
      bchk(pin, 1'b1);
      run_b <= 1'b0;
      wr(OCP_ADDR_CTRL, 32'h0000_0000);
      repeat (2) @(posedge hclk);
      bchk(pin, 1'b0);
      wr(OCP_ADDR_CTRL, 32'h0000_000A);
      wr(OCP_ADDR_CMPR, {16'h0000, tbb + 16'h0005});
      repeat (60) @(posedge hclk);
      bchk(pin, 1'b1);
      run_b <= 1'b1;
      repeat (20) @(posedge hclk);
      bchk(pin, 1'b0);
      run_b <= 1'b0;
      tend("set modes");
      wr(OCP_ADDR_CMPR, 32'h0000_000A);
      wr(OCP_ADDR_CTRL, 32'h0000_0003);
      repeat (2) @(posedge hclk);
      meas(160);
      chk(e, 4);
      cpu_idle <= 1'b1;
      meas(160);
      chk(e, 4);
      wr(OCP_ADDR_CTRL, 32'h0000_2003);
      meas(160);
      chk(e, 0);
      cpu_idle <= 1'b0;
      tend("toggle and idle");
      wr(OCP_ADDR_CMPS, 32'h0000_0019);
      wr(OCP_ADDR_CTRL, 32'h0000_0004);
      meas(160);
      chk(r, 1);
      bchk(pin, 1'b0);
      rd(OCP_ADDR_STAT, 32'h0000_0005);
      wr(OCP_ADDR_CTRL, 32'h0000_0005);
      meas(160);
      chk(r, 4);
      tend("pulses");
      cmp = 16'h0001 + 16'($urandom % 30);
      wr(OCP_ADDR_CMPR, {16'h0000, cmp});
      trip <= 1'b1;
      wr(OCP_ADDR_CTRL, 32'h0000_0006);
      repeat (41) @(posedge hclk);
      meas(160);
      chk(h, 4 * int'(cmp));
      trip <= 1'b0;
      flt_b <= 1'b1;
      wr(OCP_ADDR_CTRL, 32'h0000_0007);
      repeat (41) @(posedge hclk);
      meas(160);
      chk(h, 4 * int'(cmp));
      bchk(pin5, 1'b0);
      rd(OCP_ADDR_CTRL, 32'h0000_0007);
      flt_b <= 1'b0;
      tend("pwm");
      wr(OCP_ADDR_MASK, 32'h0000_0002);
      trip <= 1'b1;
      repeat (45) @(posedge hclk);
      bchk(pin, 1'b0);
      bchk(irq, 1'b1);
      rd(OCP_ADDR_CTRL, 32'h0000_0017);
      wr(OCP_ADDR_CTRL, 32'h0000_0007);
      rd(OCP_ADDR_CTRL, 32'h0000_0017);
      wr(OCP_ADDR_MASK, 32'h0000_0000);
      repeat (2) @(posedge hclk);
      bchk(irq, 1'b0);
      trip <= 1'b0;
      repeat (90) @(posedge hclk);
      rd(OCP_ADDR_CTRL, 32'h0000_0007);
      tend("fault");
      wr(OCP_ADDR_CTRL, 32'h0000_0000);
      wr(OCP_ADDR_STAT, 32'h0000_0007);
      repeat (80) @(posedge hclk);
      rd(OCP_ADDR_STAT, 32'h0000_0000);
      bchk(pin, 1'b0);
      tend("disable");
      test_done;
   end
endmodule // output_compare_pwm_channel_bench
